// file: fpkllp_pkg.sv
// Constants and types for the front-panel key, LED and LCD port.
// Assumes a single 100 MHz clock domain and an asynchronous host bus.
package fpkllp_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int LCD_STROBE_NS  = 450;
	localparam int SCAN_DWELL_NS  = 10000;
	// Least time rounds up
	localparam int LCD_STROBE_CYCLES = (LCD_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Dwell per row, rounded down
	localparam int SCAN_DWELL_CYCLES = SCAN_DWELL_NS / CLK_PERIOD_NS;

	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int ROWS   = 8;
	localparam int COLS   = 8;
	localparam int ROW_W  = 3;
	localparam int CNT_W  = 16;
	localparam int LCNT_W = 8;

	// Address map on panel_address_bus
	localparam logic [ADDR_W-1:0] ADDR_LCD_CMD_WR  = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_LCD_DATA_WR = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_LCD_STAT_RD = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_LCD_DATA_RD = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_LED         = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_ROW_SEL     = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_KEY_COLS    = 3'h7;
	// Addresses 0 to 3 go to the LCD module; bit 0 is its register select
	localparam int ADDR_LCD_SEL_BIT = 2;
	localparam int ADDR_RS_BIT      = 0;

	// Host bus pins after sampling, converted to active high
	typedef struct packed {
		logic              cs;
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpkllp_bus_type;

	// Whole state of the port
	typedef struct packed {
		fpkllp_bus_type         bus_s1;
		fpkllp_bus_type         bus_s2;
		logic                   acc_prev;
		logic [DATA_W-1:0]      led;
		logic [ROW_W-1:0]       row_sel;
		logic [ROWS*COLS-1:0]   key_map;
		logic [ROW_W-1:0]       scan_row;
		logic [CNT_W-1:0]       scan_cnt;
		logic [COLS-1:0]        col_s1;
		logic [COLS-1:0]        col_s2;
		logic [LCNT_W-1:0]      lcd_cnt;
		logic                   lcd_rs;
		logic                   lcd_rw_n;
		logic                   lcd_strobe;
		logic [DATA_W-1:0]      rd_data;
		logic                   drive;
	} fpkllp_state_type;

endpackage : fpkllp_pkg

// file: fpkllp_top.sv
// Front-panel port: host data/address bus, LCD strobes, LED drive, key scan.
// Assumes host strobes and key columns are asynchronous to clk.
//
// What this block does
// - Host talks over 8-bit two-way data bus and 3-bit host-driven address.
// - Port generates LCD strobe, read/write and register select lines.
// - Each of eight LED outputs follows its own bit of written LED data.
// - LED outputs are active low: low lights, high keeps dark.
// - Key pressed when its column reads low while its row is driven low.
// - Eight active-low row outputs, eight active-low column inputs, 64 keys.
`timescale 1ns/10ps

module fpkllp_top #(
	parameter int SCAN_CYCLES = fpkllp_pkg::SCAN_DWELL_CYCLES,
	parameter int LCD_CYCLES  = fpkllp_pkg::LCD_STROBE_CYCLES
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// Host bus
	input  wire logic                          panel_cs_n,
	input  wire logic                          panel_rd_n,
	input  wire logic                          panel_wr_n,
	input  wire logic [fpkllp_pkg::ADDR_W-1:0] panel_address_bus,
	input  wire logic [fpkllp_pkg::DATA_W-1:0] panel_data_in,
	output logic      [fpkllp_pkg::DATA_W-1:0] panel_data_out,
	output logic                               panel_data_oe_n,
	// LCD module control
	output logic                               lcd_strobe,
	output logic                               lcd_read_write_n,
	output logic                               lcd_register_select,
	// LEDs
	output logic      [fpkllp_pkg::DATA_W-1:0] led_drive_n,
	// Key matrix
	output logic      [fpkllp_pkg::ROWS-1:0]   key_row_drive_n,
	input  wire logic [fpkllp_pkg::COLS-1:0]   key_column_sense_n
);

	if (SCAN_CYCLES < 4 || SCAN_CYCLES >= (1 << fpkllp_pkg::CNT_W)) begin : g_bad_scan
		$error("SCAN_CYCLES out of range");
	end
	if (LCD_CYCLES < 1 || LCD_CYCLES >= (1 << fpkllp_pkg::LCNT_W)) begin : g_bad_lcd
		$error("LCD_CYCLES out of range");
	end
	if (fpkllp_pkg::ROWS != (1 << fpkllp_pkg::ROW_W)) begin : g_bad_rows
		$error("ROWS must match the row index width");
	end
	if (fpkllp_pkg::COLS != fpkllp_pkg::DATA_W) begin : g_bad_cols
		$error("One key row must fill one data byte");
	end
	if (fpkllp_pkg::ADDR_LCD_SEL_BIT >= fpkllp_pkg::ADDR_W) begin : g_bad_sel
		$error("LCD select bit lies outside the address bus");
	end

	localparam logic [fpkllp_pkg::CNT_W-1:0]  SCAN_RELOAD = fpkllp_pkg::CNT_W'(SCAN_CYCLES - 1);
	localparam logic [fpkllp_pkg::LCNT_W-1:0] LCD_RELOAD  = fpkllp_pkg::LCNT_W'(LCD_CYCLES - 1);

	fpkllp_pkg::fpkllp_state_type state_ff;
	fpkllp_pkg::fpkllp_state_type nxt_state;

	// Addresses answered by the port itself on a read
	function automatic logic is_local_read(input logic [fpkllp_pkg::ADDR_W-1:0] a);
		is_local_read = (a == fpkllp_pkg::ADDR_LED) || (a == fpkllp_pkg::ADDR_ROW_SEL) ||
		                (a == fpkllp_pkg::ADDR_KEY_COLS);
	endfunction : is_local_read

	// One-hot active-low row pattern
	function automatic logic [fpkllp_pkg::ROWS-1:0] row_pattern_n(
		input logic [fpkllp_pkg::ROW_W-1:0] r);
		row_pattern_n = ~(fpkllp_pkg::ROWS'(1) << r);
	endfunction : row_pattern_n

	// First key-map bit of a row
	function automatic int row_base(input logic [fpkllp_pkg::ROW_W-1:0] r);
		row_base = int'(r) * fpkllp_pkg::COLS;
	endfunction : row_base

	// Stored columns of one row, pressed = 1
	function automatic logic [fpkllp_pkg::COLS-1:0] row_keys(
		input logic [fpkllp_pkg::ROWS*fpkllp_pkg::COLS-1:0] map,
		input logic [fpkllp_pkg::ROW_W-1:0]                 r);
		row_keys = map[row_base(r) +: fpkllp_pkg::COLS];
	endfunction : row_keys

	// Rows are visited in rising order and wrap after the last
	function automatic logic [fpkllp_pkg::ROW_W-1:0] next_row(
		input logic [fpkllp_pkg::ROW_W-1:0] r);
		next_row = r + fpkllp_pkg::ROW_W'(1);
	endfunction : next_row

	// Addresses with the select bit clear reach the LCD module
	function automatic logic is_lcd_addr(input logic [fpkllp_pkg::ADDR_W-1:0] a);
		is_lcd_addr = ~a[fpkllp_pkg::ADDR_LCD_SEL_BIT];
	endfunction : is_lcd_addr

	// Port drives the data bus only while a local read is held
	function automatic logic drives_bus(input fpkllp_pkg::fpkllp_bus_type b);
		drives_bus = b.cs & b.rd & is_local_read(b.addr);
	endfunction : drives_bus

	// Byte returned for a local read
	function automatic logic [fpkllp_pkg::DATA_W-1:0] read_byte(
		input logic [fpkllp_pkg::ADDR_W-1:0]                a,
		input logic [fpkllp_pkg::DATA_W-1:0]                led,
		input logic [fpkllp_pkg::ROW_W-1:0]                 row_sel,
		input logic [fpkllp_pkg::ROWS*fpkllp_pkg::COLS-1:0] map);
		case (a)
			fpkllp_pkg::ADDR_LED: begin
				read_byte = led;
			end
			fpkllp_pkg::ADDR_ROW_SEL: begin
				read_byte = fpkllp_pkg::DATA_W'(row_sel);
			end
			fpkllp_pkg::ADDR_KEY_COLS: begin
				read_byte = fpkllp_pkg::DATA_W'(row_keys(map, row_sel));
			end
			default: begin
				read_byte = '0;
			end
		endcase
	endfunction : read_byte

	always_comb begin
		fpkllp_pkg::fpkllp_state_type s;
		logic                          acc;
		logic                          start;
		s     = state_ff;
		acc   = 1'b0;
		start = 1'b0;

		// Two-stage sampling of the host bus, as active-high levels
		// Address and data share the strobes' flops so all stay aligned;
		// the host holds them at least four clocks from the strobe edge
		s.bus_s1.cs   = ~panel_cs_n;
		s.bus_s1.rd   = ~panel_rd_n;
		s.bus_s1.wr   = ~panel_wr_n;
		s.bus_s1.addr = panel_address_bus;
		s.bus_s1.data = panel_data_in;
		s.bus_s2      = state_ff.bus_s1;

		// An access starts on the first sampled cycle of cs with rd or wr
		// Edge detect: one action per strobe, however long it is held
		acc   = state_ff.bus_s2.cs & (state_ff.bus_s2.rd | state_ff.bus_s2.wr);
		start = acc & ~state_ff.acc_prev;
		s.acc_prev = acc;

		// LCD strobe timing
		if (state_ff.lcd_strobe) begin
			if (state_ff.lcd_cnt == '0) begin
				s.lcd_strobe = 1'b0;
			end else begin
				s.lcd_cnt = state_ff.lcd_cnt - fpkllp_pkg::LCNT_W'(1);
			end
		end

		if (start) begin
			if (is_lcd_addr(state_ff.bus_s2.addr)) begin
				// LCD access: the module itself moves data on the bus
				// A further LCD access restarts the strobe
				s.lcd_rs     = state_ff.bus_s2.addr[fpkllp_pkg::ADDR_RS_BIT];
				s.lcd_rw_n   = state_ff.bus_s2.rd;
				s.lcd_strobe = 1'b1;
				s.lcd_cnt    = LCD_RELOAD;
			end else if (state_ff.bus_s2.wr) begin
				case (state_ff.bus_s2.addr)
					fpkllp_pkg::ADDR_LED: begin
						s.led = state_ff.bus_s2.data;
					end
					fpkllp_pkg::ADDR_ROW_SEL: begin
						s.row_sel = state_ff.bus_s2.data[fpkllp_pkg::ROW_W-1:0];
					end
					default: begin
					end
				endcase
			end
		end

		// Read data follows the address every cycle
		s.drive   = drives_bus(state_ff.bus_s2);
		s.rd_data = read_byte(state_ff.bus_s2.addr, state_ff.led, state_ff.row_sel,
		                      state_ff.key_map);

		// Column inputs, two-stage, converted to pressed = 1
		s.col_s1 = ~key_column_sense_n;
		s.col_s2 = state_ff.col_s1;

		// Row scan: sample at end of dwell, then step to next row
		// Counting up gives row 0 its full dwell straight after reset
		// No diodes assumed: three closed keys on a rectangle show a fourth
		if (state_ff.scan_cnt == SCAN_RELOAD) begin
			s.key_map[row_base(state_ff.scan_row) +: fpkllp_pkg::COLS] =
				state_ff.col_s2;
			s.scan_row = next_row(state_ff.scan_row);
			s.scan_cnt = '0;
		end else begin
			s.scan_cnt = state_ff.scan_cnt + fpkllp_pkg::CNT_W'(1);
		end

		nxt_state = s;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Host data bus
	assign panel_data_out      = state_ff.rd_data;
	assign panel_data_oe_n     = ~state_ff.drive;
	// LCD control lines
	assign lcd_strobe          = state_ff.lcd_strobe;
	assign lcd_read_write_n    = state_ff.lcd_rw_n;
	assign lcd_register_select = state_ff.lcd_rs;
	// LED and key row drive
	assign led_drive_n         = ~state_ff.led;
	assign key_row_drive_n     = row_pattern_n(state_ff.scan_row);

endmodule : fpkllp_top

// file: fpkllp_top_chk.sv
// Port checker for the front-panel port.
// Bound to fpkllp_top; one clock domain.
`timescale 1ns/10ps
module fpkllp_top_chk #(
	parameter int LCD_CYCLES = 45
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// Host bus
	input wire logic       panel_rd_n,
	input wire logic       panel_wr_n,
	input wire logic [2:0] panel_address_bus,
	input wire logic [7:0] panel_data_in,
	input wire logic       panel_data_oe_n,
	// Panel side
	input wire logic       lcd_strobe,
	input wire logic       lcd_read_write_n,
	input wire logic       lcd_register_select,
	input wire logic [7:0] led_drive_n,
	input wire logic [7:0] key_row_drive_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	logic [7:0] hi_cnt_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) hi_cnt_ff <= 8'h00;
		else hi_cnt_ff <= lcd_strobe ? hi_cnt_ff + 8'h01 : 8'h00;
	end
	a_one_row_low: assert property ($onehot(~key_row_drive_n))
		else $error("row drive not one-hot");
	a_row_next_up: assert property ($changed(key_row_drive_n) |->
		key_row_drive_n == ($past(key_row_drive_n) << 1 | $past(key_row_drive_n) >> 7))
		else $error("row order");
	a_led_from_bit: assert property ($fell(panel_wr_n) && panel_address_bus == 3'h4
		|-> ##[1:4] led_drive_n == ~panel_data_in) else $error("led value");
	a_led_cause: assert property ($changed(led_drive_n) |-> !$past(panel_wr_n, 2))
		else $error("led change without write");
	a_lcd_width: assert property ($fell(lcd_strobe) |-> hi_cnt_ff == 8'(LCD_CYCLES))
		else $error("lcd strobe width");
	a_lcd_lines: assert property ($rose(lcd_strobe) |-> lcd_read_write_n == panel_wr_n
		&& lcd_register_select == panel_address_bus[0]) else $error("lcd control");
	a_bus_release: assert property ($rose(panel_rd_n) |-> ##[1:4] panel_data_oe_n)
		else $error("bus not released");
	c_lcd: cover property ($rose(lcd_strobe) && lcd_read_write_n);
	c_read: cover property ($fell(panel_data_oe_n));
	c_led: cover property ($changed(led_drive_n));
endmodule : fpkllp_top_chk

// file: fpkllp_host.sv
// Host board model: one panel access at a time.
// Assumes the bench resolves the data wire into bus_in.
`timescale 1ns/10ps
module fpkllp_host (
	// Clock and wire
	input  wire logic       clk,
	input  wire logic [7:0] bus_in,
	// Host pins
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [2:0]      addr,
	output logic [7:0]      dout
);
	initial begin
		{cs_n, rd_n, wr_n} = 3'h7;
		addr = 3'h0;
		dout = 8'h5a;
	end
	// Strobe low 8 clocks, high 4; idle data inverted so stale values show
	task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		{cs_n, rd_n, wr_n} <= {1'b0, !rd, rd};
		addr <= a;
		dout <= rd ? ~dout : d;
		repeat (8) @(posedge clk);
		q = bus_in;
		{cs_n, rd_n, wr_n} <= 3'h7;
		dout <= ~dout;
		repeat (4) @(posedge clk);
	endtask : acc
endmodule : fpkllp_host

// file: fpkllp_top_tb.sv
// Bench for the front-panel port with host model and key matrix.
// Assumes short scan and strobe counts.
`timescale 1ns/10ps
module fpkllp_top_tb;
	logic       clk, reset_n, cs_n, rd_n, wr_n, oe_n, strb, rwn, rs;
	logic [2:0] addr;
	logic [7:0] hd, pdo, din, led_n, rows_n, cols_n, q;
	logic [63:0] keys;
	int         failures, num_checks, strb_hi;
	localparam int LCD_N = 3;
	// Clocks seen with the LCD strobe high
	always @(posedge clk) begin
		if (strb === 1'b1) begin
			strb_hi <= strb_hi + 1;
		end
	end
	assign din = oe_n ? hd : pdo;
	// Closed key pulls its column low while its row is driven low
	always_comb begin
		cols_n = 8'hff;
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				if (keys[r*8 + c] && !rows_n[r]) begin
					cols_n[c] = 1'b0;
				end
			end
		end
	end
	fpkllp_top #(.SCAN_CYCLES(8), .LCD_CYCLES(LCD_N)) dut_u (.clk(clk), .reset_n(reset_n),
		.panel_cs_n(cs_n), .panel_rd_n(rd_n), .panel_wr_n(wr_n), .panel_address_bus(addr),
		.panel_data_in(din), .panel_data_out(pdo), .panel_data_oe_n(oe_n), .lcd_strobe(strb),
		.lcd_read_write_n(rwn), .lcd_register_select(rs), .led_drive_n(led_n),
		.key_row_drive_n(rows_n), .key_column_sense_n(cols_n));
	fpkllp_host u_host (.clk(clk), .bus_in(din), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .dout(hd));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic t_led;
		logic [7:0] pat [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
		foreach (pat[i]) begin
			u_host.acc(1'b0, 3'h4, pat[i], q);
			chk("led_drive_n", ~pat[i], led_n);
			u_host.acc(1'b1, 3'h4, 8'h00, q);
			chk("led readback", pat[i], q);
		end
		u_host.acc(1'b0, 3'h5, 8'h0f, q);
		chk("led_drive_n after unused write", 8'hc3, led_n);
		$display("led test done");
	endtask : t_led
	task automatic t_lcd;
		int base;
		for (int a = 0; a < 4; a++) begin
			base = strb_hi;
			u_host.acc(a[1], 3'(a), 8'h30, q);
			chk("lcd_strobe width", 8'(LCD_N), 8'(strb_hi - base));
			chk("lcd_register_select", 8'(a[0]), {7'h0, rs});
			chk("lcd_read_write_n", 8'(a[1]), {7'h0, rwn});
		end
		$display("lcd test done");
	endtask : t_lcd
	task automatic t_keys(input logic [63:0] k);
		@(posedge clk);
		keys <= k;
		repeat (160) @(posedge clk);
		for (int r = 0; r < 8; r++) begin
			u_host.acc(1'b0, 3'h6, 8'(r), q);
			u_host.acc(1'b1, 3'h7, 8'h00, q);
			chk("key row", k[r*8 +: 8], q);
		end
		$display("key test done");
	endtask : t_keys
	task automatic t_reset;
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk("reset led_drive_n", 8'hff, led_n);
		chk("reset key_row_drive_n", 8'hfe, rows_n);
		chk("reset lcd lines", 8'h00, {6'h0, rwn, rs});
		chk("reset lcd_strobe", 8'h00, {7'h0, strb});
		chk("reset panel_data_oe_n", 8'h01, {7'h0, oe_n});
		$display("reset test done");
	endtask : t_reset
	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{reset_n, failures, num_checks} = '0;
		keys = '0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk("reset rows", 8'hfe, rows_n);
		t_led();
		t_lcd();
		t_reset();
		t_keys(64'h8000_0000_0020_0001);
		t_keys(64'h0);
		conclude();
	end
	initial begin
		#100000;
		failures++;
		conclude();
	end
endmodule : fpkllp_top_tb
bind fpkllp_top fpkllp_top_chk #(.LCD_CYCLES(LCD_CYCLES)) u_chk (.clk(clk),
	.reset_n(reset_n), .panel_rd_n(panel_rd_n), .panel_wr_n(panel_wr_n),
	.panel_address_bus(panel_address_bus), .panel_data_in(panel_data_in),
	.panel_data_oe_n(panel_data_oe_n), .lcd_strobe(lcd_strobe),
	.lcd_read_write_n(lcd_read_write_n), .lcd_register_select(lcd_register_select),
	.led_drive_n(led_drive_n), .key_row_drive_n(key_row_drive_n));
